// ---- rtl/cfe_defines.svh ----
// Offsets, field positions, codes and counts of the coil evaluator
// What this block does
// - Direct coil copies rung result immediately
// - Negated coil drives inverse of rung result
// - Falling edge coil pulses one scan
// - Rising edge coil pulses one scan
// - Last evaluated coil instance sets relay
// - Set and reset coils may repeat
// - Expansion relays are markers without expansion
// - 128 rungs, three series contacts, one coil
// - Adjacent filled fields link automatically, permanently
// - Cursor buttons are contacts with enable
// - Buttons sampled only on status screen
// - Report cursor state with four codes
// - Edit in STOP, evaluate in RUN
// - Delete only empty rungs, shift up
// - Impulse coil toggles on rising result
// - Lower of set and reset wins
// - STOP clears coils except retentive ones
`ifndef CFE_DEFINES_SVH
`define CFE_DEFINES_SVH

`define CFE_OFF_CTRL 8'h00
`define CFE_OFF_STATUS 8'h04
`define CFE_OFF_RETAIN_LO 8'h08
`define CFE_OFF_RETAIN_HI 8'h0c
`define CFE_OFF_EDIT_IDX 8'h10
`define CFE_OFF_EDIT_CONTACTS 8'h14
`define CFE_OFF_EDIT_COIL 8'h18
`define CFE_OFF_EDIT_CMD 8'h1c
`define CFE_OFF_RELAY_LO 8'h20
`define CFE_OFF_RELAY_HI 8'h24

`define CFE_CTRL_RUN 0
`define CFE_CTRL_CUR_EN 1
`define CFE_ST_RUNNING 0
`define CFE_ST_REFUSED 1
`define CFE_ST_CODE_LO 2
`define CFE_ST_BTN_LO 4
`define CFE_ST_BUSY 6

`define CFE_CMD_WRITE 2'h1
`define CFE_CMD_INSERT 2'h2
`define CFE_CMD_DELETE 2'h3

`define CFE_CODE_BLANK 2'h0
`define CFE_CODE_ACTIVE 2'h1
`define CFE_CODE_PRESSED 2'h2
`define CFE_CODE_INACTIVE 2'h3

`define CFE_RUNGS 128
`define CFE_LAST_RUNG 7'h7f
`define CFE_IN_BASE 6'h00
`define CFE_Q_BASE 6'h10
`define CFE_S_BASE 6'h28
`define CFE_CUR_BASE 6'h30
`define CFE_CUR_TOP 6'h33

`define CFE_RESP_OKAY 2'h0
`define CFE_RESP_SLVERR 2'h2

`endif

// ---- rtl/cfe_pkg.sv ----
// Types of the coil evaluator
package cfe_pkg;

	typedef enum logic [2:0] {
		CF_CONTACT,
		CF_NEGATE,
		CF_FALL,
		CF_RISE,
		CF_IMPULSE,
		CF_SET,
		CF_RESET
	} cfe_coil_e;

	typedef enum logic [1:0] {
		ST_STOP,
		ST_SCAN,
		ST_COMMIT,
		ST_SHIFT
	} cfe_state_e;

	typedef struct packed {
		logic present;
		logic neg;
		logic link;
		logic [5:0] src;
	} cfe_field_s;

	typedef struct packed {
		cfe_field_s [2:0] f;
		logic coil_on;
		cfe_coil_e func;
		logic [5:0] tgt;
	} cfe_rung_s;

	typedef struct packed {
		cfe_rung_s [127:0] mem;
		logic [127:0] prev;
		logic [63:0] relay;
		logic [63:0] retain;
		logic run_en;
		logic cur_en;
		logic refused;
		cfe_state_e state;
		logic [6:0] idx;
		logic [6:0] edit_idx;
		logic [26:0] st_contacts;
		logic [9:0] st_coil;
		logic shift_down;
		logic [6:0] sh_cnt;
		logic used_acc;
		logic used;
		logic [3:0] pressed;
		logic [7:0] q_out;
		logic [7:0] s_out;
		logic [1:0] cur_code;
		logic scan_done;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cfe_regs_s;

endpackage

// ---- rtl/cfe_top.sv ----
// Ladder scan coil evaluator with AXI4-Lite register access
`timescale 1ns/100ps
`include "cfe_defines.svh"

module cfe_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] field_in,
	input wire logic [3:0] cursor_button,
	input wire logic status_screen,
	input wire logic expansion_present,
	output logic [7:0] out_terminal,
	output logic [7:0] exp_terminal,
	output logic [1:0] cursor_code,
	output logic scan_done
);

	cfe_pkg::cfe_regs_s s;
	cfe_pkg::cfe_regs_s n;

	// Series chain of three fields
	function automatic logic rung_eval(input cfe_pkg::cfe_rung_s r,
		input logic [63:0] rel);
		logic c;
		c = r.coil_on;
		for (int i = 2; i >= 0; i--) begin
			if (r.f[i].present) begin
				c = c & (rel[r.f[i].src] ^ r.f[i].neg);
			end else if (!r.f[i].link) begin
				c = 1'b0;
			end
		end
		return c;
	endfunction

	// Inputs and cursor contacts are never coil targets
	function automatic logic writable(input logic [5:0] t);
		return (t >= `CFE_Q_BASE) &&
			!((t >= `CFE_CUR_BASE) && (t <= `CFE_CUR_TOP));
	endfunction

	function automatic logic uses_cursor(input cfe_pkg::cfe_rung_s r);
		logic u;
		u = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (r.f[i].present && (r.f[i].src >= `CFE_CUR_BASE) &&
				(r.f[i].src <= `CFE_CUR_TOP)) begin
				u = 1'b1;
			end
		end
		return u;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic [1:0] lowest_set(input logic [3:0] b);
		logic [1:0] k;
		k = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (b[i]) begin
				k = 2'(i);
			end
		end
		return k;
	endfunction

	always_comb begin
		logic res;
		logic old_res;
		logic set_ref;
		logic clr_ref;
		logic [31:0] wv;
		logic [31:0] m;
		logic [63:0] im;
		cfe_pkg::cfe_rung_s cur;
		cfe_pkg::cfe_rung_s nr;
		res = 1'b0;
		old_res = 1'b0;
		set_ref = 1'b0;
		clr_ref = 1'b0;
		wv = 32'h0;
		m = 32'h0;
		im = 64'h0;
		cur = s.mem[s.idx];
		nr = '0;
		n = s;
		n.scan_done = 1'b0;

		// Cursor buttons only count on the status screen
		// status screen sampling
		if (status_screen) begin
			n.pressed = cursor_button;
		end

		case (s.state)
			cfe_pkg::ST_STOP: begin
				if (s.run_en) begin
					n.prev = 128'h0;
					n.idx = 7'h0;
					n.used_acc = 1'b0;
					n.state = cfe_pkg::ST_COMMIT;
				end
			end
			cfe_pkg::ST_SCAN: begin
				// one rung per cycle, 128 rungs
				res = rung_eval(cur, s.relay);
				old_res = s.prev[s.idx];
				n.prev[s.idx] = res;
				if (uses_cursor(cur)) begin
					n.used_acc = 1'b1;
				end
				if (cur.coil_on && writable(cur.tgt)) begin
					case (cur.func)
						cfe_pkg::CF_CONTACT: n.relay[cur.tgt] = res;
						cfe_pkg::CF_NEGATE: n.relay[cur.tgt] = !res;
						cfe_pkg::CF_FALL: n.relay[cur.tgt] = old_res & !res;
						cfe_pkg::CF_RISE: n.relay[cur.tgt] = !old_res & res;
						cfe_pkg::CF_IMPULSE: begin
							if (!old_res && res) begin
								n.relay[cur.tgt] = !s.relay[cur.tgt];
							end
						end
						cfe_pkg::CF_SET: begin
							if (res) begin
								n.relay[cur.tgt] = 1'b1;
							end
						end
						cfe_pkg::CF_RESET: begin
							// lower coil wins by scan order
							if (res) begin
								n.relay[cur.tgt] = 1'b0;
							end
						end
						default: begin
						end
					endcase
				end
				if (s.idx == `CFE_LAST_RUNG) begin
					n.state = cfe_pkg::ST_COMMIT;
				end
				n.idx = s.idx + 7'h1;
			end
			cfe_pkg::ST_COMMIT: begin
				n.q_out = s.relay[`CFE_Q_BASE +: 8];
				n.s_out = expansion_present ? s.relay[`CFE_S_BASE +: 8] :
					8'h0;
				n.used = s.used_acc;
				n.used_acc = 1'b0;
				n.scan_done = 1'b1;
				n.relay[`CFE_IN_BASE +: 16] = field_in;
				n.relay[`CFE_CUR_BASE +: 4] = s.cur_en ? s.pressed : 4'h0;
				n.idx = 7'h0;
				n.state = cfe_pkg::ST_SCAN;
			end
			cfe_pkg::ST_SHIFT: begin
				if (s.shift_down) begin
					if (s.sh_cnt == s.edit_idx) begin
						n.mem[s.sh_cnt] = '0;
						n.state = cfe_pkg::ST_STOP;
					end else begin
						n.mem[s.sh_cnt] = s.mem[s.sh_cnt - 7'h1];
						n.sh_cnt = s.sh_cnt - 7'h1;
					end
				end else begin
					if (s.sh_cnt == `CFE_LAST_RUNG) begin
						n.mem[s.sh_cnt] = '0;
						n.state = cfe_pkg::ST_STOP;
					end else begin
						n.mem[s.sh_cnt] = s.mem[s.sh_cnt + 7'h1];
						n.sh_cnt = s.sh_cnt + 7'h1;
					end
				end
			end
			default: n.state = cfe_pkg::ST_STOP;
		endcase

		if (!s.run_en && (s.state == cfe_pkg::ST_SCAN ||
			s.state == cfe_pkg::ST_COMMIT)) begin
			n.relay = s.relay & s.retain;
			n.q_out = 8'h0;
			n.s_out = 8'h0;
			n.state = cfe_pkg::ST_STOP;
		end

		if (!s.used) begin
			n.cur_code = `CFE_CODE_BLANK;
		end else if (!s.cur_en) begin
			n.cur_code = `CFE_CODE_INACTIVE;
		end else if (|s.pressed) begin
			n.cur_code = `CFE_CODE_PRESSED;
		end else begin
			n.cur_code = `CFE_CODE_ACTIVE;
		end

		// Write channel: address and data in either order
		if (s_axi_awvalid && s.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `CFE_RESP_OKAY;
			wv = s.wdata;
			case ({s.awaddr[7:2], 2'b00})
				`CFE_OFF_CTRL: begin
					m = merge({30'h0, s.cur_en, s.run_en}, wv, s.wstrb);
					n.run_en = m[`CFE_CTRL_RUN];
					n.cur_en = m[`CFE_CTRL_CUR_EN];
				end
				`CFE_OFF_STATUS: begin
					if (s.wstrb[0]) begin
						clr_ref = wv[`CFE_ST_REFUSED];
					end
				end
				`CFE_OFF_RETAIN_LO: n.retain[31:0] =
					merge(s.retain[31:0], wv, s.wstrb);
				`CFE_OFF_RETAIN_HI: n.retain[63:32] =
					merge(s.retain[63:32], wv, s.wstrb);
				`CFE_OFF_EDIT_IDX: begin
					m = merge({25'h0, s.edit_idx}, wv, s.wstrb);
					n.edit_idx = m[6:0];
				end
				`CFE_OFF_EDIT_CONTACTS: begin
					m = merge({5'h0, s.st_contacts}, wv, s.wstrb);
					n.st_contacts = m[26:0];
				end
				`CFE_OFF_EDIT_COIL: begin
					m = merge({22'h0, s.st_coil}, wv, s.wstrb);
					n.st_coil = m[9:0];
				end
				`CFE_OFF_EDIT_CMD: begin
					im = 64'h0;
					nr = {s.st_contacts, s.st_coil};
					// edits only while stopped and idle
					if (s.run_en || s.state != cfe_pkg::ST_STOP ||
						!s.wstrb[0]) begin
						set_ref = 1'b1;
					end else begin
						case (wv[1:0])
							`CFE_CMD_WRITE: n.mem[s.edit_idx] = nr;
							`CFE_CMD_INSERT: begin
								n.shift_down = 1'b1;
								n.sh_cnt = `CFE_LAST_RUNG;
								n.state = cfe_pkg::ST_SHIFT;
							end
							`CFE_CMD_DELETE: begin
								// only rungs with no contacts or coil
								if (s.mem[s.edit_idx].coil_on ||
									s.mem[s.edit_idx].f[0].present ||
									s.mem[s.edit_idx].f[1].present ||
									s.mem[s.edit_idx].f[2].present) begin
									set_ref = 1'b1;
								end else begin
									n.shift_down = 1'b0;
									n.sh_cnt = s.edit_idx;
									n.state = cfe_pkg::ST_SHIFT;
								end
							end
							default: begin
							end
						endcase
					end
				end
				`CFE_OFF_RELAY_LO, `CFE_OFF_RELAY_HI: begin
				end
				default: n.bresp = `CFE_RESP_SLVERR;
			endcase
		end
		n.refused = (s.refused & !clr_ref) | set_ref;
		n.awready = !n.aw_got;
		n.wready = !n.w_got;

		// Read channel
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rresp = `CFE_RESP_OKAY;
			n.rdata = 32'h0;
			case ({s_axi_araddr[7:2], 2'b00})
				`CFE_OFF_CTRL: n.rdata = {30'h0, s.cur_en, s.run_en};
				`CFE_OFF_STATUS: begin
					n.rdata[`CFE_ST_RUNNING] = s.state == cfe_pkg::ST_SCAN ||
						s.state == cfe_pkg::ST_COMMIT;
					n.rdata[`CFE_ST_REFUSED] = s.refused;
					n.rdata[`CFE_ST_CODE_LO +: 2] = s.cur_code;
					n.rdata[`CFE_ST_BTN_LO +: 2] = lowest_set(s.pressed);
					n.rdata[`CFE_ST_BUSY] = s.state == cfe_pkg::ST_SHIFT;
				end
				`CFE_OFF_RETAIN_LO: n.rdata = s.retain[31:0];
				`CFE_OFF_RETAIN_HI: n.rdata = s.retain[63:32];
				`CFE_OFF_EDIT_IDX: n.rdata = {25'h0, s.edit_idx};
				`CFE_OFF_EDIT_CONTACTS: n.rdata = {5'h0, s.mem[s.edit_idx].f};
				`CFE_OFF_EDIT_COIL: n.rdata = {22'h0,
					s.mem[s.edit_idx].coil_on, s.mem[s.edit_idx].func,
					s.mem[s.edit_idx].tgt};
				`CFE_OFF_EDIT_CMD: n.rdata = 32'h0;
				`CFE_OFF_RELAY_LO: n.rdata = s.relay[31:0];
				`CFE_OFF_RELAY_HI: n.rdata = s.relay[63:32];
				default: n.rresp = `CFE_RESP_SLVERR;
			endcase
		end
		n.arready = !n.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.state <= cfe_pkg::ST_STOP;
		end else begin
			s <= n;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign out_terminal = s.q_out;
	assign exp_terminal = s.s_out;
	assign cursor_code = s.cur_code;
	assign scan_done = s.scan_done;

endmodule

// ---- bench/cfe_top_props.sv ----
// Port assertions of the coil evaluator
`timescale 1ns/100ps
module cfe_top_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic expansion_present,
	input wire logic [7:0] out_terminal,
	input wire logic [7:0] exp_terminal,
	input wire logic scan_done
);
	logic [7:0] gap;
	logic seen;
	// Cycles since the last commit
	always_ff @(posedge aclk) begin
		if (!aresetn || scan_done)
			gap <= 8'h00;
		else
			gap <= gap + 8'h01;
		if (!aresetn)
			seen <= 1'b0;
		else if (scan_done)
			seen <= 1'b1;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	aw_hold_a: assert property (s_axi_awvalid && s_axi_awready
		|=> !s_axi_awready) else $error("awready not dropped");
	w_hold_a: assert property (s_axi_wvalid && s_axi_wready
		|=> !s_axi_wready) else $error("wready not dropped");
	b_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read data late");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("bvalid kept after taken");
	r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while data pending");
	scan_gap_a: assert property (
		scan_done && seen |-> gap == 8'd128)
		else $error("scan length wrong");
	exp_off_a: assert property (
		scan_done && !$past(expansion_present) |-> exp_terminal == 8'h00)
		else $error("expansion terminals driven without unit");
	out_commit_a: assert property (
		$changed(out_terminal) |-> scan_done || out_terminal == 8'h00)
		else $error("terminals changed outside commit");
endmodule

bind cfe_top cfe_top_props i_props (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .expansion_present, .out_terminal, .exp_terminal,
	.scan_done);

// ---- bench/cfe_panel_model.sv ----
// Field input and front panel model
`timescale 1ns/100ps
module cfe_panel_model (
	input wire logic aclk,
	input wire logic [15:0] set_field,
	input wire logic [3:0] set_btn,
	input wire logic set_scr,
	input wire logic set_exp,
	output logic [15:0] field_in,
	output logic [3:0] cursor_button,
	output logic status_screen,
	output logic expansion_present
);
	initial begin
		field_in = 16'h0000;
		cursor_button = 4'h0;
		status_screen = 1'b0;
		expansion_present = 1'b0;
	end
	// Levels move just after an edge
	always @(posedge aclk) begin
		field_in <= set_field;
		cursor_button <= set_btn;
		status_screen <= set_scr;
		expansion_present <= set_exp;
	end
endmodule

// ---- bench/coil_function_evaluator_tb.sv ----
// Testbench of the coil evaluator
`timescale 1ns/100ps
module coil_function_evaluator_tb;
	logic aclk = 0, aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0, outt, expt;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata, rv;
	logic [3:0] wstrb = 0, bset = 0, btn;
	logic awready, wready, bvalid, arready, rvalid, sd, scr, exq;
	logic [1:0] bresp, rresp, code, rr, br;
	logic [15:0] fset = 0, fin;
	logic sset = 0, eset = 0;
	int n_errors = 0, total_checks = 0;
	// {inputs, btn, screen, exp, 0} out exp code
	logic [31:0] rows [10] = '{32'h00020001, 32'h10850001, 32'h02460001,
		32'h12810101, 32'h30090001, 32'h70110001, 32'hd0190001,
		32'h1c290002, 32'h10290002, 32'h14090001};
	always #5 aclk = ~aclk;
	cfe_panel_model i_pan (.aclk(aclk), .set_field(fset), .set_btn(bset),
		.set_scr(sset), .set_exp(eset), .field_in(fin),
		.cursor_button(btn), .status_screen(scr), .expansion_present(exq));
	cfe_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .field_in(fin), .cursor_button(btn),
		.status_screen(scr), .expansion_present(exq),
		.out_terminal(outt), .exp_terminal(expt), .cursor_code(code),
		.scan_done(sd));
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 999) begin
			n_errors++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			tick(n);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		br = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			tick(n);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	task automatic sc(input int k);
		int n;
		repeat (k) begin
			n = 0;
			do
				tick(n);
			while (!sd);
		end
	endtask
	task automatic idle();
		int k;
		k = 0;
		do begin
			rd(8'h04);
			k++;
		end while (rv[6] && k < 99);
		chk("busy", rv[6], 0);
		if (rv[6])
			wrap_up();
	endtask
	// One contact in the leftmost field, linked empties after it
	task automatic rung(input logic [6:0] i, input logic [5:0] s,
		input logic [2:0] f, input logic [5:0] t);
		wr(8'h10, i);
		wr(8'h14, {3'b100, s, 9'h040, 9'h040});
		wr(8'h18, {1'b1, f, t});
		wr(8'h1c, 1);
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("awready", awready, 1);
		chk("out", outt, 0);
		chk("code", code, 0);
		rd(8'h00);
		chk("ctrl", rv, 0);
		rd(8'h28);
		chk("bad rdata", rv, 0);
		chk("bad rresp", rr, 2);
		wr(8'h28, 1);
		chk("bad bresp", br, 2);
		rung(0, 0, 0, 16);
		rung(1, 0, 1, 17);
		rung(2, 0, 2, 24);
		rung(3, 0, 3, 25);
		rung(4, 0, 4, 18);
		rung(5, 1, 5, 19);
		rung(6, 2, 6, 19);
		rung(7, 3, 5, 19);
		rung(8, 1, 0, 20);
		rung(9, 2, 0, 20);
		rung(10, 0, 0, 40);
		rung(11, 48, 0, 21);
		rung(12, 24, 0, 22);
		rung(13, 25, 0, 23);
		// Break contact on I1 into an N marker
		wr(8'h10, 14);
		wr(8'h14, {3'b110, 6'h01, 9'h040, 9'h040});
		wr(8'h18, {1'b1, 3'h0, 6'h34});
		wr(8'h1c, 1);
		wr(8'h00, 3);
		for (int i = 0; i < 10; i++) begin
			fset <= {12'h000, rows[i][31:28]};
			bset <= {3'h0, rows[i][27]};
			sset <= rows[i][26];
			eset <= rows[i][25];
			sc(2);
			// Cursor report lags the commit by one cycle
			@(posedge aclk);
			chk("out", outt, rows[i][23:16]);
			chk("exp", expt, rows[i][15:8]);
			chk("code", code, rows[i][1:0]);
		end
		bset <= 4'h1;
		wr(8'h00, 1);
		sc(2);
		chk("code off", code, 3);
		chk("out off", outt, 8'h09);
		wr(8'h1c, 1);
		rd(8'h04);
		chk("run edit", rv[1:0], 3);
		wr(8'h08, 32'h80000);
		wr(8'h0c, 32'h100000);
		wr(8'h00, 0);
		rd(8'h20);
		chk("retain", rv, 32'h80000);
		chk("out stop", outt, 0);
		rd(8'h24);
		chk("retain hi", rv, 32'h100000);
		wr(8'h04, 2);
		wr(8'h10, 0);
		wr(8'h1c, 3);
		rd(8'h04);
		chk("del full", rv[1], 1);
		wr(8'h04, 2);
		wr(8'h1c, 2);
		idle();
		wr(8'h10, 1);
		rd(8'h14);
		chk("shifted", rv, 32'h4008040);
		wr(8'h10, 0);
		wr(8'h1c, 3);
		idle();
		chk("del ok", rv[1], 0);
		rd(8'h14);
		chk("pulled", rv, 32'h4008040);
		wrap_up();
	end
endmodule
